// ---- sfei_flash.sv ----
// Serial flash erase sequencer with identification readout over SPI.
`include "sfei_consts.svh"

module sfei_flash
  import sfei_pkg::*;
#(
  parameter logic [7:0]   MAKER_ID      = 8'h5a, // Arbitrary value.
  parameter logic [7:0]   DEVICE_ID     = 8'h16, // Arbitrary value.
  parameter logic [7:0]   MEM_TYPE_ID   = 8'h40, // Arbitrary value.
  parameter logic [7:0]   CAPACITY_ID   = 8'h17, // Arbitrary value.
  parameter logic [127:0] UNIQUE_ID     = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, // Arbitrary value.
  parameter int           AREA_BITS     = 23,
  parameter int           T_SE_CYC      = `SFEI_T_SE_CYC,
  parameter int           T_BE1_CYC     = `SFEI_T_BE1_CYC,
  parameter int           T_BE2_CYC     = `SFEI_T_BE2_CYC,
  parameter int           T_CE_CYC      = `SFEI_T_CE_CYC
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe_n,
  // Protection configuration
  input  wire sfei_prot_t  prot,
  // Status
  output logic             write_enable_latch,
  output logic             write_in_progress_flag,
  // Erase request towards the array
  output sfei_erase_req_t  erase_req,
  output logic [23:0]      erase_base
);

  initial
  begin
    if (AREA_BITS < 17 || AREA_BITS > 24 || T_SE_CYC < 1 || T_BE1_CYC < 1 || T_BE2_CYC < 1 || T_CE_CYC < 1)
      $error("sfei_flash: unsupported parameter values.");
  end

  // Pin synchronisers.
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] si_sync;
  logic       cs_q;
  logic       sck_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h0;
      si_sync  <= 2'h0;
      cs_q     <= 1'b1;
      sck_q    <= 1'b0;
    end
    else
    begin
      cs_sync  <= {cs_sync[0], cs_n};
      sck_sync <= {sck_sync[0], sclk};
      si_sync  <= {si_sync[0], si};
      cs_q     <= cs_sync[1];
      sck_q    <= sck_sync[1];
    end
  end

  wire cs_low   = ~cs_sync[1];
  wire cs_rise  = cs_sync[1] & ~cs_q;
  wire sck_rise = cs_low & sck_sync[1] & ~sck_q;
  wire sck_fall = cs_low & ~sck_sync[1] & sck_q;

  // Input shift state.
  logic [`SFEI_CNT_W-1:0] bit_cnt;
  logic [7:0]             opcode;
  logic [23:0]            addr;
  logic [6:0]             rx_byte;
  logic                   opc_done;

  wire [7:0] rx_full   = {rx_byte, si_sync[1]};
  wire [7:0] next_cnt  = bit_cnt + 8'd1;
  wire       last_opc  = sck_rise && bit_cnt == 8'd7;

  always_ff @(posedge ref_clk)
  begin
    if (rst || cs_rise || ~cs_low)
    begin
      bit_cnt  <= 8'h00;
      rx_byte  <= 7'h00;
      opc_done <= 1'b0;
      if (rst)
      begin
        opcode <= 8'h00;
        addr   <= 24'h000000;
      end
    end
    else if (sck_rise)
    begin
      // Bits captured on rising clock edges, MSB first.
      bit_cnt <= (bit_cnt == 8'hff) ? bit_cnt : next_cnt;
      rx_byte <= rx_full[6:0];
      if (bit_cnt == 8'd7)
      begin
        opcode   <= rx_full;
        opc_done <= 1'b1;
      end
      else if (opc_done && bit_cnt < 8'd32)
        addr <= {addr[22:0], si_sync[1]};
    end
  end

  // Command decode.
  wire is_sector  = opcode == `SFEI_OP_SECTOR;
  wire is_b32     = opcode == `SFEI_OP_BLK32;
  wire is_b64     = opcode == `SFEI_OP_BLK64;
  wire is_chip    = opcode == `SFEI_OP_CHIP_A || opcode == `SFEI_OP_CHIP_B;
  wire is_addr_er = is_sector | is_b32 | is_b64;
  // Select must rise exactly after the last address bit or the opcode byte.
  wire seq_ok     = opc_done && ((is_addr_er && bit_cnt == 8'd32) || (is_chip && bit_cnt == 8'd8));

  function automatic logic [23:0] align_down(input logic [23:0] a, input int shift);
    align_down = (a >> shift) << shift;
  endfunction

  // Protected span from the low three protect bits: the top 2^(n-1) blocks of 64 KB, inverted by the complement bit.
  wire [2:0]  bp_low    = prot.bp[2:0];
  wire [4:0]  prot_lvl  = {2'b00, bp_low};
  wire [23:0] area_top  = 24'((64'd1 << AREA_BITS) - 64'd1);
  wire [23:0] prot_size = (bp_low == 3'd0) ? 24'h000000 : 24'(64'd65536 << (prot_lvl - 5'd1));
  wire [23:0] prot_low  = 24'({1'b0, area_top} + 25'd1 - {1'b0, prot_size});
  wire        in_upper  = prot_size != 24'h000000 && addr >= prot_low;
  wire        addr_prot = prot.cmp ? ~in_upper : in_upper;
  wire        chip_ok   = (bp_low == 3'b000 && !prot.cmp) || (bp_low == 3'b111 && prot.cmp);
  wire        protected_hit = is_chip ? ~chip_ok : addr_prot;

  wire [23:0] next_base = is_sector ? align_down(addr, `SFEI_SECTOR_SHIFT) :
                          is_b32    ? align_down(addr, `SFEI_BLK32_SHIFT)  :
                          is_b64    ? align_down(addr, `SFEI_BLK64_SHIFT)  : 24'h000000;
  wire [31:0] next_time = is_sector ? 32'(T_SE_CYC) : is_b32 ? 32'(T_BE1_CYC) :
                          is_b64 ? 32'(T_BE2_CYC) : 32'(T_CE_CYC);
  wire sfei_erase_t next_kind = is_sector ? SFEI_OP_SE : is_b32 ? SFEI_OP_B32 :
                                is_b64 ? SFEI_OP_B64 : SFEI_OP_CE;

  wire write_enable_cmd_seen   = cs_rise && opc_done && opcode == `SFEI_OP_WRITE_ENABLE_CMD && bit_cnt == 8'd8 && !write_in_progress_flag;
  wire erase_valid = cs_rise && seq_ok && !write_in_progress_flag;
  wire erase_go    = erase_valid && write_enable_latch && !protected_hit;
  wire erase_deny  = erase_valid && write_enable_latch && protected_hit;

  // Self-timed erase cycle.
  logic [31:0] busy_cnt;
  wire         busy_done = write_in_progress_flag && busy_cnt == 32'd1;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      write_in_progress_flag <= 1'b0;
      busy_cnt               <= 32'h0;
      erase_req              <= '0;
      erase_base             <= 24'h000000;
    end
    else
    begin
      erase_req.start <= erase_go;
      if (erase_go)
      begin
        write_in_progress_flag <= 1'b1;
        busy_cnt               <= next_time;
        erase_req.kind         <= next_kind;
        erase_req.addr         <= addr;
        erase_base             <= next_base;
      end
      else if (busy_done)
        write_in_progress_flag <= 1'b0;
      else if (write_in_progress_flag)
        busy_cnt <= busy_cnt - 32'd1;
    end
  end

  // Latch cleared as the cycle starts, or when an erase is refused for protection.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      write_enable_latch <= 1'b0;
    else if (erase_go || erase_deny)
      write_enable_latch <= 1'b0;
    else if (write_enable_cmd_seen)
      write_enable_latch <= 1'b1;
  end

  // Identification readout.
  wire id_blocked = write_in_progress_flag;
  wire sfei_idkind_t next_idk = id_blocked ? SFEI_ID_NONE :
                                rx_full == `SFEI_OP_MAKER_DEV ? SFEI_ID_MD :
                                rx_full == `SFEI_OP_IDENT     ? SFEI_ID_JEDEC :
                                rx_full == `SFEI_OP_UNIQUE    ? SFEI_ID_UID : SFEI_ID_NONE;

  sfei_idkind_t idk;
  logic [127:0] tx_shift;
  wire [7:0]    prefix = (idk == SFEI_ID_UID) ? `SFEI_UID_PREFIX :
                         (idk == SFEI_ID_MD)  ? `SFEI_MD_PREFIX  : `SFEI_ID_PREFIX;
  wire          tx_phase = idk != SFEI_ID_NONE && bit_cnt >= prefix;

  always_ff @(posedge ref_clk)
  begin
    if (rst || ~cs_low)
    begin
      idk      <= SFEI_ID_NONE;
      tx_shift <= '0;
      // Data keeps its last level while released, so it only moves on a falling clock edge.
      if (rst)
        so <= 1'b0;
      so_oe_n  <= 1'b1;
    end
    else
    begin
      if (last_opc)
      begin
        idk <= next_idk;
        case (next_idk)
          SFEI_ID_MD:    tx_shift <= {MAKER_ID, DEVICE_ID, 112'h0};
          SFEI_ID_JEDEC: tx_shift <= {MAKER_ID, MEM_TYPE_ID, CAPACITY_ID, 104'h0};
          SFEI_ID_UID:   tx_shift <= UNIQUE_ID;
          default:       tx_shift <= '0;
        endcase
      end
      else if (sck_fall && tx_phase)
      begin
        so       <= tx_shift[127];
        so_oe_n  <= 1'b0;
        tx_shift <= {tx_shift[126:0], 1'b0};
      end
    end
  end

  wip_after_go_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_go |=> write_in_progress_flag && !write_enable_latch)
    else $error("Busy flag not set or latch not cleared after erase start.");

  no_go_wo_wel_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(write_in_progress_flag) |-> $past(write_enable_latch))
    else $error("Erase started without write enable latch.");

  deny_clears_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_deny |=> !write_enable_latch && !write_in_progress_flag)
    else $error("Protected erase was not refused.");

  chip_prot_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_go && is_chip |-> chip_ok)
    else $error("Chip erase started while protected.");

  seq_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_go && is_addr_er |-> bit_cnt == 8'd32)
    else $error("Address erase started with wrong bit count.");

  base_align_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_req.start && erase_req.kind == SFEI_OP_SE |-> erase_base[11:0] == 12'h000)
    else $error("Sector base not aligned.");

  b64_align_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_req.start && erase_req.kind == SFEI_OP_B64 |-> erase_base[15:0] == 16'h0000)
    else $error("Large block base not aligned.");

  id_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
    last_opc && write_in_progress_flag |=> idk == SFEI_ID_NONE)
    else $error("Identification decoded during erase.");

  cs_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    !cs_low |=> so_oe_n)
    else $error("Output still driven after select rose.");

  so_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(so) |-> $past(sck_fall))
    else $error("Output changed outside a falling clock edge.");

  wel_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    write_enable_cmd_seen |=> write_enable_latch)
    else $error("Write enable command did not set the latch.");

  start_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_req.start |=> !erase_req.start)
    else $error("Erase start held longer than one cycle.");

  b32_align_a: assert property (@(posedge ref_clk) disable iff (rst)
    erase_req.start && erase_req.kind == SFEI_OP_B32 |-> erase_base[14:0] == 15'h0000)
    else $error("Small block base not aligned.");

  oe_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    idk == SFEI_ID_NONE |-> so_oe_n)
    else $error("Output driven without an identification command.");
endmodule

// ---- sfei_consts.svh ----
// Constants for the serial flash erase and identification block.
`ifndef SFEI_CONSTS_SVH
`define SFEI_CONSTS_SVH
`define SFEI_OP_WRITE_ENABLE_CMD        8'h06
`define SFEI_OP_SECTOR      8'h20
`define SFEI_OP_BLK32       8'h52
`define SFEI_OP_BLK64       8'hd8
`define SFEI_OP_CHIP_A      8'h60
`define SFEI_OP_CHIP_B      8'hc7
`define SFEI_OP_MAKER_DEV   8'h90
`define SFEI_OP_IDENT       8'h9f
`define SFEI_OP_UNIQUE      8'h4b
`define SFEI_ADDR_BITS      24
`define SFEI_OPC_BITS       8
`define SFEI_CNT_W          8
`define SFEI_UID_PREFIX     8'd40
`define SFEI_MD_PREFIX      8'd32
`define SFEI_ID_PREFIX      8'd8
`define SFEI_SECTOR_SHIFT   12
`define SFEI_BLK32_SHIFT    15
`define SFEI_BLK64_SHIFT    16
`define SFEI_T_SE_CYC       32'd1000
`define SFEI_T_BE1_CYC      32'd4000
`define SFEI_T_BE2_CYC      32'd8000
`define SFEI_T_CE_CYC       32'd20000
`endif

// ---- sfei_pkg.sv ----
// Types shared by the serial flash erase and identification block.
package sfei_pkg;
  typedef enum logic [2:0] {
    SFEI_OP_NONE,
    SFEI_OP_SE,
    SFEI_OP_B32,
    SFEI_OP_B64,
    SFEI_OP_CE
  } sfei_erase_t;

  typedef enum logic [1:0] {
    SFEI_ID_NONE,
    SFEI_ID_MD,
    SFEI_ID_JEDEC,
    SFEI_ID_UID
  } sfei_idkind_t;

  typedef struct packed {
    logic [5:0] bp;
    logic       cmp;
  } sfei_prot_t;

  typedef struct packed {
    logic        start;
    sfei_erase_t kind;
    logic [23:0] addr;
  } sfei_erase_req_t;
endpackage

// ---- sfei_host.sv ----
// SPI host model that drives command frames into the flash block.
module sfei_host
  import sfei_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // Sends ntx bits from the top of tx, then clocks nrx bits in from so.
  // No power-down mode exists in this model, so identification is never sent there.
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
                       output logic [127:0] rx, output logic oe_seen);
    rx = '0;
    oe_seen = 1'b0;
    repeat (8) @(negedge ref_clk);
    cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++)
    begin
      si = (i < ntx) ? tx[39 - i] : ~si;
      repeat (5) @(negedge ref_clk);
      sclk = 1'b1;
      if (i >= ntx)
        rx = {rx[126:0], so};
      oe_seen = oe_seen | ~so_oe_n;
      repeat (5) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    cs_n = 1'b1;
    si   = ~si;
  endtask
endmodule

// ---- sfei_flash_tb_top.sv ----
// Self-checking testbench for the serial flash erase and identification block.
`include "sfei_consts.svh"
module sfei_flash_tb_top
  import sfei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T_SE  = 20;
  localparam int T_B32 = 30;
  localparam int T_B64 = 40;
  localparam int T_CE  = 400;
  localparam logic [7:0]   MAKER = 8'h3c; // Arbitrary value.
  localparam logic [7:0]   DEVID = 8'h21; // Arbitrary value.
  localparam logic [7:0]   MTYPE = 8'h44; // Arbitrary value.
  localparam logic [7:0]   CAPAC = 8'h15; // Arbitrary value.
  localparam logic [127:0] UID   = 128'h1111_2222_3333_4444_a5a5_5a5a_0f0f_f0f0; // Arbitrary value.

  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  logic            cs_n, sclk, si, so, so_oe_n;
  sfei_prot_t      prot = '0;
  logic            write_enable_latch, write_in_progress_flag;
  sfei_erase_req_t erase_req;
  logic [23:0]     erase_base, addr;
  logic [127:0]    rx;
  logic            oe, model_wel = 1'b0;
  int              fail_count = 0, compares = 0, cyc = 0, seed = 2;

  sfei_flash #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID), .MEM_TYPE_ID(MTYPE), .CAPACITY_ID(CAPAC), .UNIQUE_ID(UID),
    .T_SE_CYC(T_SE), .T_BE1_CYC(T_B32), .T_BE2_CYC(T_B64), .T_CE_CYC(T_CE)) dut_u (.ref_clk(ref_clk),
    .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n), .prot(prot),
    .write_enable_latch(write_enable_latch), .write_in_progress_flag(write_in_progress_flag),
    .erase_req(erase_req), .erase_base(erase_base));

  sfei_host host_u (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n));

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 25000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Optionally sets the latch, sends one erase frame and checks it against the bench model.
  task automatic do_erase(input logic en, input logic [7:0] op, input logic [23:0] a, input int nbits,
                          input sfei_erase_t kind, input int shift, input int tcyc, input logic hit);
    int   c0;
    logic good, run;
    if (en)
    begin
      host_u.frame({`SFEI_OP_WRITE_ENABLE_CMD, 32'h0}, 8, 0, rx, oe);
      repeat (8) @(negedge ref_clk);
      model_wel = 1'b1;
      check("latch set", 1, write_enable_latch);
    end
    good = (nbits == ((kind == SFEI_OP_CE) ? 8 : 32));
    run = model_wel && good && !hit;
    host_u.frame({op, a, 8'h00}, nbits, 0, rx, oe);
    c0 = cyc;
    if (run)
    begin
      while (erase_req.start !== 1'b1 && cyc < c0 + 20)
        @(negedge ref_clk);
      check("erase start", 1, erase_req.start);
      check("erase kind", kind, erase_req.kind);
      check("erase base", (kind == SFEI_OP_CE) ? 0 : (a >> shift) << shift, erase_base);
      if (kind != SFEI_OP_CE)
        check("erase addr", a, erase_req.addr);
      check("busy", 1, write_in_progress_flag);
      if (kind == SFEI_OP_CE)
      begin
        host_u.frame({`SFEI_OP_IDENT, 32'h0}, 8, 24, rx, oe);
        check("so enable while busy", 0, oe);
        check("busy after ident", 1, write_in_progress_flag);
      end
      while (write_in_progress_flag === 1'b1 && cyc < c0 + tcyc + 30)
        @(negedge ref_clk);
      check("busy length", 1, (cyc - c0 >= tcyc) && (cyc - c0 <= tcyc + 8));
    end
    else
    begin
      repeat (20) @(negedge ref_clk);
      check("busy refused", 0, write_in_progress_flag);
    end
    if (run || (hit && good))
      model_wel = 1'b0;
    check("latch after erase", model_wel, write_enable_latch);
  endtask

  initial
  begin
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    check("latch at reset", 0, write_enable_latch);
    check("busy at reset", 0, write_in_progress_flag);
    check("so enable at reset", 1, so_oe_n);
    host_u.frame({`SFEI_OP_IDENT, 32'h0}, 8, 24, rx, oe);
    check("ident", {MAKER, MTYPE, CAPAC}, rx[23:0]);
    check("so enable ident", 1, oe);
    host_u.frame({`SFEI_OP_MAKER_DEV, 32'h0}, 32, 16, rx, oe);
    check("maker device", {MAKER, DEVID}, rx[15:0]);
    host_u.frame({`SFEI_OP_UNIQUE, 32'h0}, 40, 128, rx, oe);
    check("unique id", UID, rx);
    host_u.frame({`SFEI_OP_IDENT, 32'h0}, 8, 4, rx, oe);
    repeat (8) @(negedge ref_clk);
    check("ident nibble", MAKER[7:4], rx[3:0]);
    check("so enable after stop", 1, so_oe_n);
    addr = 24'($random(seed)) & 24'h7fffff;
    do_erase(1'b0, `SFEI_OP_SECTOR, addr, 32, SFEI_OP_SE, 12, T_SE, 1'b0);
    do_erase(1'b1, `SFEI_OP_SECTOR, addr, 32, SFEI_OP_SE, 12, T_SE, 1'b0);
    addr = 24'($random(seed)) & 24'h7fffff;
    do_erase(1'b1, `SFEI_OP_BLK32, addr, 32, SFEI_OP_B32, 15, T_B32, 1'b0);
    addr = 24'($random(seed)) & 24'h7fffff;
    do_erase(1'b1, `SFEI_OP_BLK64, addr, 32, SFEI_OP_B64, 16, T_B64, 1'b0);
    do_erase(1'b1, `SFEI_OP_CHIP_A, 24'h0, 8, SFEI_OP_CE, 0, T_CE, 1'b0);
    do_erase(1'b1, `SFEI_OP_CHIP_B, 24'h0, 9, SFEI_OP_CE, 0, T_CE, 1'b0);
    do_erase(1'b0, `SFEI_OP_SECTOR, addr, 31, SFEI_OP_SE, 12, T_SE, 1'b0);
    do_erase(1'b0, `SFEI_OP_CHIP_B, 24'h0, 8, SFEI_OP_CE, 0, T_CE, 1'b0);
    prot = '{bp: 6'h01, cmp: 1'b0};
    do_erase(1'b1, `SFEI_OP_SECTOR, 24'h7f0000 | addr[15:0], 32, SFEI_OP_SE, 12, T_SE, 1'b1);
    do_erase(1'b1, `SFEI_OP_CHIP_A, 24'h0, 8, SFEI_OP_CE, 0, T_CE, 1'b1);
    prot = '{bp: 6'h07, cmp: 1'b1};
    do_erase(1'b1, `SFEI_OP_CHIP_A, 24'h0, 8, SFEI_OP_CE, 0, T_CE, 1'b0);
    finish_test();
  end
endmodule
